/* File: slps_pkg.sv */
/*
  Shared constants and types of the serial link and printer supervisor.
  Assumes a single 20 MHz core clock.
*/
package slps_pkg;
  localparam longint CLK_HZ = 20_000_000;
  // input conditioning
  localparam longint DEB_TIME_US = 100;
  localparam int DEB_CYCLES =
    int'((CLK_HZ * DEB_TIME_US + 999_999) / 1_000_000);
  localparam int DEB_W = 12;
  localparam int NIN = 7;
  localparam int IN_RTS = 0;
  localparam int IN_DTR = 1;
  localparam int IN_TMARK = 2;
  localparam int IN_PRINT = 3;
  localparam int IN_DATA = 4;
  localparam int IN_THR = 5;
  localparam int IN_ALARM = 6;
  // audible tone
  localparam longint TONE_TIME_MS = 1000;
  localparam int TONE_CYCLES = int'(CLK_HZ * TONE_TIME_MS / 1000);
  localparam int TONE_W = 25;
  // channels walked by a summary
  localparam logic [2:0] CHAN_FIRST = 3'h1;
  localparam logic [2:0] CHAN_LAST = 3'h5;
  // remote command characters
  localparam logic [7:0] CMD_THRESHOLD_SUMMARY_KEY = 8'h50;
  localparam logic [7:0] CMD_DATA = 8'h44;
  localparam logic [7:0] CMD_CAL = 8'h43;
  // reset value and sizes
  localparam logic PRN_EN_RST = 1'b1;
  localparam int TIME_W = 32;
  localparam int NPEND = 10;
  typedef enum logic [3:0] {
    MSG_LOST, MSG_RESTORED, MSG_PON, MSG_POFF, MSG_TMARK, MSG_ECHO,
    MSG_BADCHAR, MSG_CAL, MSG_DATA, MSG_THR, MSG_DATA_CH, MSG_THR_CH
  } slps_msg_t;
  typedef struct packed {
    slps_msg_t code;
    logic [2:0] chan;
    logic [7:0] ch;
    logic [TIME_W-1:0] time_cs;
  } slps_rec_t;
  localparam int MSG_W = $bits(slps_rec_t);
endpackage

/* File: slps_stream_if.sv */
/*
  Valid/ready word stream between the supervisor and its buffers.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface slps_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // slps_stream_if

/* File: slps_debounce.sv */
/*
  Two-flop synchroniser and stability filter for a group of slow inputs.
  Assumes inputs are slow levels; settled rises once after reset.
*/
`timescale 1ns/10ps
module slps_debounce
  import slps_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // levels
  input wire logic [NIN-1:0] raw,
  output logic [NIN-1:0] clean,
  output logic settled
);
  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] cln;
    logic [NIN-1:0][DEB_W-1:0] cnt;
    logic [DEB_W:0] boot;
    logic done;
  } slps_deb_t;
  slps_deb_t r, n;
  logic [NIN-1:0] cln_nx;
  logic [NIN-1:0][DEB_W-1:0] cnt_nx;

  // a level is taken only after it held for the full filter time
  for (genvar i = 0; i < NIN; i++)
  begin : g_bit
    assign cln_nx[i] = (r.cnt[i] == DEB_W'(DEB_CYCLES - 1)) ?
                       r.s2[i] : r.cln[i];
    assign cnt_nx[i] = (r.s2[i] == r.cln[i] ||
                        r.cnt[i] == DEB_W'(DEB_CYCLES - 1)) ? '0 :
                       r.cnt[i] + 1'b1;
  end

  always_comb
  begin
    n = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.cln = cln_nx;
    n.cnt = cnt_nx;
    if (!r.done)
    begin
      n.boot = r.boot + 1'b1;
      n.done = (r.boot == (DEB_W + 1)'(DEB_CYCLES + 2));
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign clean = r.cln;
  assign settled = r.done;
endmodule // slps_debounce

/* File: slps_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; in ready and out valid come from the count flops.
*/
`timescale 1ns/10ps
module slps_buffer #(parameter int W = 8)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // streams
  slps_stream_if.snk in_s,
  slps_stream_if.src out_s
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } slps_buf_t;
  slps_buf_t r, n;
  logic push, pop;

  always_comb
  begin
    n = r;
    push = in_s.valid && r.cnt != 2'h2;
    pop = out_s.ready && r.cnt != 2'h0;
    if (push)
    begin
      n.mem[r.wr] = in_s.data;
      n.wr = ~r.wr;
    end
    if (pop)
      n.rd = ~r.rd;
    n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign in_s.ready = r.cnt != 2'h2;
  assign out_s.valid = r.cnt != 2'h0;
  assign out_s.data = r.mem[r.rd];
endmodule // slps_buffer

/* File: slps_supervisor.sv */
/*
  Serial link and printer supervisor: link watch, printer enable,
  remote commands, echo, summaries, time mark and alarm tone.
  Assumes all inputs synchronous to core_clk; a formatter downstream
  turns message records into printed lines.
*/
`timescale 1ns/10ps
module slps_supervisor #(parameter int TONE_LEN = slps_pkg::TONE_CYCLES)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial control lines
  input wire logic rts_in,
  input wire logic dtr_in,
  output logic cts_out,
  output logic dsr_out,
  // received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic rx_ready,
  // printed line copy to the serial transmitter
  input wire logic line_valid,
  input wire logic [7:0] line_char,
  output logic line_ready,
  output logic tx_valid,
  output logic [7:0] tx_char,
  input wire logic tx_ready,
  // front panel and system
  input wire logic print_key,
  input wire logic data_key,
  input wire logic threshold_summary_key,
  input wire logic alarm_key,
  input wire logic operate_mode,
  input wire logic time_mark_in,
  input wire logic end_of_day,
  input wire logic disturbance_evt,
  input wire logic [slps_pkg::TIME_W-1:0] time_now,
  // status and command pulses
  output logic printer_en,
  output logic link_lost,
  output logic alarm_tone,
  output logic cmd_threshold_summary_key,
  output logic cmd_data,
  output logic cmd_cal,
  // message records to the formatter
  output logic msg_valid,
  output slps_pkg::slps_rec_t msg_rec,
  input wire logic msg_ready
);
  import slps_pkg::*;

  typedef enum logic {ST_PICK, ST_CHAN} slps_st_t;
  typedef struct packed {
    slps_st_t st;
    logic [NPEND-1:0] pend;
    slps_msg_t sum_code;
    logic [2:0] chan;
    logic en;
    logic lost;
    logic saved;
    logic started;
    logic link_q;
    logic [NIN-1:0] key_q;
    logic [7:0] ch;
    logic [TONE_W-1:0] tone_cnt;
    logic tone;
    logic tx_hold;
    logic tx_v;
    logic [7:0] tx_c;
    logic cts;
    logic dsr;
    logic rx_rdy;
    logic cmd_p;
    logic cmd_d;
    logic cmd_c;
    logic push_v;
    slps_rec_t push_rec;
  } slps_top_t;
  slps_top_t r, n;

  logic [NIN-1:0] cl, rise;
  logic settled, link_ok;
  slps_msg_t pick;
  slps_stream_if #(.W(MSG_W)) msg_in ();
  slps_stream_if #(.W(MSG_W)) msg_out ();
  slps_stream_if #(.W(8)) tx_in ();
  slps_stream_if #(.W(8)) tx_out ();

  function automatic slps_msg_t first_set(logic [NPEND-1:0] p);
    logic [3:0] idx;
    idx = '0;
    for (int i = NPEND - 1; i >= 0; i--)
      if (p[i])
        idx = 4'(i);
    return slps_msg_t'(idx);
  endfunction

  slps_debounce u_deb (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raw({alarm_key, threshold_summary_key, data_key, print_key,
          time_mark_in, dtr_in, rts_in}),
    .clean(cl),
    .settled(settled)
  );

  slps_buffer #(.W(MSG_W)) u_msg_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_s(msg_in),
    .out_s(msg_out)
  );

  slps_buffer #(.W(8)) u_tx_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_s(tx_in),
    .out_s(tx_out)
  );

  assign link_ok = cl[IN_RTS] & cl[IN_DTR];
  assign rise = cl & ~r.key_q;
  assign pick = first_set(r.pend);
  assign msg_in.valid = r.push_v;
  assign msg_in.data = r.push_rec;
  assign msg_out.ready = msg_ready;
  assign tx_in.valid = line_valid;
  assign tx_in.data = line_char;
  assign tx_out.ready = !r.tx_hold;

  always_comb
  begin
    n = r;
    n.key_q = cl;
    n.cmd_p = 1'b0;
    n.cmd_d = 1'b0;
    n.cmd_c = 1'b0;
    n.cts = 1'b1;
    n.dsr = 1'b1;
    // emission first, so an event set below wins over the clear
    if (r.push_v && msg_in.ready)
      n.push_v = 1'b0;
    if (!n.push_v && (r.st == ST_CHAN || r.pend != '0))
    begin
      n.push_v = 1'b1;
      n.push_rec.time_cs = time_now;
      n.push_rec.ch = r.ch;
      if (r.st == ST_CHAN)
      begin
        n.push_rec.code = r.sum_code;
        n.push_rec.chan = r.chan;
        n.chan = r.chan + 3'h1;
        if (r.chan == CHAN_LAST)
          n.st = ST_PICK;
      end
      else
      begin
        n.push_rec.code = pick;
        n.push_rec.chan = '0;
        n.pend[pick] = 1'b0;
        if (pick == MSG_DATA || pick == MSG_THR)
        begin
          n.st = ST_CHAN;
          n.chan = CHAN_FIRST;
          n.sum_code = (pick == MSG_DATA) ? MSG_DATA_CH : MSG_THR_CH;
          n.cmd_d = pick == MSG_DATA;
          n.cmd_p = pick == MSG_THR;
        end
        n.cmd_c = pick == MSG_CAL;
      end
    end
    if (!r.started)
    begin
      // wait for the filters so a floating line is not judged early
      if (settled)
      begin
        n.started = 1'b1;
        n.link_q = link_ok;
        if (!link_ok)
        begin
          n.lost = 1'b1;
          n.saved = r.en;
          n.pend[MSG_LOST] = 1'b1;
        end
      end
    end
    else
    begin
      n.link_q = link_ok;
      if (!link_ok && r.link_q && !r.lost)
      begin
        n.lost = 1'b1;
        n.saved = r.en;
        n.en = 1'b1;
        n.pend[MSG_LOST] = 1'b1;
        if (!r.en)
          n.pend[MSG_PON] = 1'b1;
      end
      else if (link_ok && !r.link_q && r.lost)
      begin
        n.lost = 1'b0;
        n.en = r.saved;
        n.pend[MSG_RESTORED] = 1'b1;
        if (!r.saved)
          n.pend[MSG_POFF] = 1'b1;
      end
      if (rise[IN_PRINT])
      begin
        if (n.lost)
        begin
          n.pend[MSG_LOST] = 1'b1;
          n.pend[MSG_PON] = 1'b1;
        end
        else
        begin
          n.en = !n.en;
          n.pend[MSG_PON] = !n.en ? 1'b0 : 1'b1;
          n.pend[MSG_POFF] = !n.en ? 1'b1 : 1'b0;
        end
      end
      if (end_of_day)
        n.en = 1'b1;
      if (rise[IN_DATA] && operate_mode)
        n.pend[MSG_DATA] = 1'b1;
      if (rise[IN_THR] && operate_mode)
        n.pend[MSG_THR] = 1'b1;
      if (rise[IN_TMARK])
        n.pend[MSG_TMARK] = 1'b1;
      if (r.rx_rdy && rx_valid)
      begin
        n.ch = rx_char;
        if (rx_char == CMD_THRESHOLD_SUMMARY_KEY)
          n.pend[MSG_THR] = 1'b1;
        else if (rx_char == CMD_DATA)
          n.pend[MSG_DATA] = 1'b1;
        else if (rx_char == CMD_CAL)
          n.pend[MSG_CAL] = 1'b1;
        if (n.en && (rx_char == CMD_THRESHOLD_SUMMARY_KEY || rx_char == CMD_DATA ||
                     rx_char == CMD_CAL))
          n.pend[MSG_ECHO] = 1'b1;
        else if (n.en)
          n.pend[MSG_BADCHAR] = 1'b1;
      end
      if (cl[IN_ALARM] && disturbance_evt)
        n.tone_cnt = TONE_W'(TONE_LEN - 1);
      else if (r.tone_cnt != '0)
        n.tone_cnt = r.tone_cnt - 1'b1;
      // the event cycle plus TONE_LEN - 1 counted cycles gives TONE_LEN
      n.tone = (cl[IN_ALARM] && disturbance_evt) || r.tone_cnt != '0;
    end
    // one held character so the echo is never overwritten
    n.rx_rdy = n.started && cl[IN_DTR] && !n.pend[MSG_ECHO] &&
               !n.pend[MSG_BADCHAR];
    // a word held while request to send is low waits, not lost
    if (r.tx_v && tx_ready)
      n.tx_hold = 1'b0;
    if (!r.tx_hold && tx_out.valid)
    begin
      n.tx_hold = 1'b1;
      n.tx_c = tx_out.data;
    end
    n.tx_v = n.tx_hold && cl[IN_RTS];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
      r.en <= PRN_EN_RST;
      r.cts <= 1'b1;
      r.dsr <= 1'b1;
    end
    else
      r <= n;
  end

  assign cts_out = r.cts;
  assign dsr_out = r.dsr;
  assign rx_ready = r.rx_rdy;
  assign line_ready = tx_in.ready;
  assign tx_valid = r.tx_v;
  assign tx_char = r.tx_c;
  assign printer_en = r.en;
  assign link_lost = r.lost;
  assign alarm_tone = r.tone;
  assign cmd_threshold_summary_key = r.cmd_p;
  assign cmd_data = r.cmd_d;
  assign cmd_cal = r.cmd_c;
  assign msg_valid = msg_out.valid;
  assign msg_rec = slps_rec_t'(msg_out.data);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_cts_dsr_on: assert property (cts_out && dsr_out)
    else $error("cts or dsr dropped");
  a_tx_rts_gate: assert property (tx_valid |-> $past(cl[IN_RTS]))
    else $error("tx valid without rts");
  a_rx_dtr_gate: assert property (rx_ready |-> $past(cl[IN_DTR]))
    else $error("rx ready without dtr");
  a_loss_forces_on: assert property ($rose(link_lost) |-> printer_en)
    else $error("printer not forced on at loss");
  a_lost_stays_on: assert property (link_lost |=> link_lost |-> printer_en)
    else $error("printer disabled while lost");
  a_restore_state: assert property ($fell(link_lost) |->
    printer_en == $past(r.saved))
    else $error("saved printer state not restored");
  a_pon_with_loss: assert property ($rose(link_lost) && r.started &&
    $past(r.started) && !$past(printer_en) |-> r.pend[MSG_PON])
    else $error("printer-on missing with loss");
  a_tone_cause: assert property ($rose(alarm_tone) |->
    $past(cl[IN_ALARM] && disturbance_evt))
    else $error("tone without alarm event");
  a_cmd_threshold_summary_key: assert property (rx_ready && rx_valid && rx_char == CMD_THRESHOLD_SUMMARY_KEY
    |=> r.pend[MSG_THR] || r.st == ST_CHAN)
    else $error("program command not taken");
endmodule // slps_supervisor

/* File: slps_term_model.sv */
/*
  Remote terminal model on the far side of the serial port.
  Assumes the bench sets link_up and slow and calls send.
*/
`timescale 1ns/10ps
module slps_term_model
(
  // clock
  input wire logic core_clk,
  // control lines
  output logic rts_in,
  output logic dtr_in,
  // characters to the device
  output logic rx_valid,
  output logic [7:0] rx_char,
  input wire logic rx_ready,
  // serial output of the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  output logic tx_ready
);
  logic link_up = 1'b1;
  logic slow = 1'b0;
  logic [1:0] cnt = 2'h0;
  // both lines move together, as with a tied cable
  assign rts_in = link_up;
  assign dtr_in = link_up;
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h5A;
    tx_ready = 1'b1;
  end
  // a slow terminal takes a character on one cycle in four
  always @(negedge core_clk)
  begin
    cnt <= cnt + 2'h1;
    tx_ready <= !slow || cnt == 2'h3;
  end
  // the idle line shows the inverse so a stale char is never reused
  task automatic send(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_char = c;
    @(posedge core_clk);
    while (rx_ready !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_char = ~c;
  endtask
endmodule // slps_term_model

/* File: slps_supervisor_tb_top.sv */
/*
  Self-checking bench of the serial link and printer supervisor.
  Assumes the terminal model; tone shortened to 20 cycles.
*/
`timescale 1ns/10ps
module slps_supervisor_tb_top;
  import slps_pkg::*;
  localparam int TONE = 20;
  localparam int SET = 2020;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  // print, data, threshold, alarm, time mark
  logic [4:0] keys = 5'h00;
  logic operate_mode = 1'b1;
  logic end_of_day = 1'b0;
  logic disturbance_evt = 1'b0;
  logic [TIME_W-1:0] time_now = 32'h0;
  logic line_valid = 1'b0;
  logic [7:0] line_char = 8'h00;
  logic msg_ready = 1'b1;
  logic rts_in, dtr_in, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_char, tx_char, bad;
  logic cts_out, dsr_out, line_ready, printer_en, link_lost, alarm_tone;
  logic cmd_threshold_summary_key, cmd_data, cmd_cal, msg_valid;
  slps_rec_t msg_rec;
  slps_rec_t exp_q[$];
  logic [7:0] tx_q[$];
  logic [31:0] seed = 32'h7E979898;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int tone_len = 0;
  int pulses = 0;
  int refused = 0;
  always #25 core_clk = ~core_clk;
  slps_supervisor #(.TONE_LEN(TONE)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n),
    .rts_in(rts_in), .dtr_in(dtr_in),
    .cts_out(cts_out), .dsr_out(dsr_out),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready),
    .line_valid(line_valid), .line_char(line_char),
    .line_ready(line_ready), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready),
    .print_key(keys[0]), .data_key(keys[1]),
    .threshold_summary_key(keys[2]), .alarm_key(keys[3]),
    .operate_mode(operate_mode), .time_mark_in(keys[4]),
    .end_of_day(end_of_day), .disturbance_evt(disturbance_evt),
    .time_now(time_now), .printer_en(printer_en),
    .link_lost(link_lost), .alarm_tone(alarm_tone),
    .cmd_threshold_summary_key(cmd_threshold_summary_key), .cmd_data(cmd_data), .cmd_cal(cmd_cal),
    .msg_valid(msg_valid), .msg_rec(msg_rec), .msg_ready(msg_ready));
  slps_term_model i_term (
    .core_clk(core_clk), .rts_in(rts_in), .dtr_in(dtr_in),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic want(input slps_msg_t c, input logic [2:0] n,
                      input logic [7:0] ch);
    slps_rec_t r;
    r = {c, n, ch, time_now};
    exp_q.push_back(r);
  endtask
  task automatic want_sum(input slps_msg_t h, input slps_msg_t c);
    want(h, 3'h0, 8'h00);
    for (int i = 1; i <= 5; i++)
      want(c, 3'(i), 8'h00);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic press(input int k);
    @(negedge core_clk);
    keys[k] = 1'b1;
    wait_cyc(SET);
    keys[k] = 1'b0;
    wait_cyc(SET);
  endtask
  // held characters only count once the link lets them out
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() + (i_term.link_up ? tx_q.size() : 0) > 0
           && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    check(n < 3000, "outputs missing");
  endtask
  task automatic put_line(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge core_clk);
    line_valid = 1'b1;
    line_char = c;
    tx_q.push_back(c);
    @(posedge core_clk);
    while (line_ready !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    @(negedge core_clk);
    line_valid = 1'b0;
    line_char = ~c;
  endtask
  task automatic cmp_msg();
    slps_rec_t e;
    check(exp_q.size() > 0, "unexpected record");
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check(msg_rec.code === e.code, "record code");
      check(msg_rec.time_cs === e.time_cs, "record time");
      if (e.code inside {MSG_ECHO, MSG_BADCHAR})
        check(msg_rec.ch === e.ch, "record char");
      if (e.code inside {MSG_DATA_CH, MSG_THR_CH})
        check(msg_rec.chan === e.chan, "record channel");
    end
  endtask
  always @(negedge core_clk)
    msg_ready <= (xs() % 4) != 0;
  always @(posedge core_clk)
  begin
    if (arst_n)
    begin
      cycles++;
      tone_len += int'(alarm_tone === 1'b1);
      pulses += int'((cmd_threshold_summary_key | cmd_data | cmd_cal) === 1'b1);
      refused += int'(line_valid && line_ready !== 1'b1);
      if (msg_valid === 1'b1 && msg_ready)
        cmp_msg();
      if (tx_valid === 1'b1 && tx_ready)
      begin
        check(tx_q.size() > 0 && tx_char === tx_q[0], "serial copy");
        if (tx_q.size() > 0)
          void'(tx_q.pop_front());
      end
      if (cycles > 70000)
      begin
        check(1'b0, "timeout");
        wrap_up();
      end
    end
  end
  initial
  begin
    time_now = xs();
    wait_cyc(12);
    arst_n = 1'b1;
    check(cts_out & dsr_out & printer_en, "reset levels");
    wait_cyc(SET);
    check(link_lost === 1'b0, "link valid");
    want(MSG_ECHO, 3'h0, CMD_THRESHOLD_SUMMARY_KEY);
    want_sum(MSG_THR, MSG_THR_CH);
    i_term.send(CMD_THRESHOLD_SUMMARY_KEY);
    drain();
    want(MSG_ECHO, 3'h0, CMD_DATA);
    want_sum(MSG_DATA, MSG_DATA_CH);
    i_term.send(CMD_DATA);
    drain();
    want(MSG_ECHO, 3'h0, CMD_CAL);
    want(MSG_CAL, 3'h0, 8'h00);
    i_term.send(CMD_CAL);
    drain();
    bad = 8'(xs());
    if (bad inside {CMD_THRESHOLD_SUMMARY_KEY, CMD_DATA, CMD_CAL})
      bad = bad ^ 8'h01;
    want(MSG_BADCHAR, 3'h0, bad);
    i_term.send(bad);
    drain();
    check(pulses == 3, "command pulses");
    time_now = xs();
    want(MSG_POFF, 3'h0, 8'h00);
    press(0);
    drain();
    check(printer_en === 1'b0, "printer off");
    want(MSG_CAL, 3'h0, 8'h00);
    i_term.send(CMD_CAL);
    drain();
    want(MSG_LOST, 3'h0, 8'h00);
    want(MSG_PON, 3'h0, 8'h00);
    i_term.link_up = 1'b0;
    wait_cyc(SET);
    drain();
    check(link_lost & printer_en, "forced on");
    check(rx_ready === 1'b0, "input refused");
    put_line(8'h4C);
    wait_cyc(20);
    check(tx_valid === 1'b0, "output held");
    want(MSG_LOST, 3'h0, 8'h00);
    want(MSG_PON, 3'h0, 8'h00);
    press(0);
    drain();
    check(printer_en === 1'b1, "stays on");
    time_now = xs();
    want(MSG_RESTORED, 3'h0, 8'h00);
    want(MSG_POFF, 3'h0, 8'h00);
    i_term.link_up = 1'b1;
    wait_cyc(SET);
    drain();
    check(!link_lost && !printer_en, "state restored");
    want(MSG_PON, 3'h0, 8'h00);
    press(0);
    want(MSG_LOST, 3'h0, 8'h00);
    i_term.link_up = 1'b0;
    wait_cyc(SET);
    drain();
    want(MSG_RESTORED, 3'h0, 8'h00);
    i_term.link_up = 1'b1;
    wait_cyc(SET);
    drain();
    check(printer_en === 1'b1, "printer on");
    time_now = xs();
    want_sum(MSG_DATA, MSG_DATA_CH);
    press(1);
    want_sum(MSG_THR, MSG_THR_CH);
    press(2);
    operate_mode = 1'b0;
    press(1);
    operate_mode = 1'b1;
    want(MSG_TMARK, 3'h0, 8'h00);
    press(4);
    drain();
    disturbance_evt = 1'b1;
    wait_cyc(1);
    disturbance_evt = 1'b0;
    keys[3] = 1'b1;
    wait_cyc(SET);
    disturbance_evt = 1'b1;
    wait_cyc(1);
    disturbance_evt = 1'b0;
    wait_cyc(40);
    check(tone_len == TONE, "tone length");
    i_term.slow = 1'b1;
    repeat (8) put_line(8'(xs()));
    drain();
    check(refused > 0, "buffer never full");
    i_term.slow = 1'b0;
    want(MSG_POFF, 3'h0, 8'h00);
    press(0);
    drain();
    end_of_day = 1'b1;
    wait_cyc(1);
    end_of_day = 1'b0;
    wait_cyc(1);
    check(printer_en === 1'b1, "day end on");
    i_term.link_up = 1'b0;
    arst_n = 1'b0;
    exp_q.delete();
    tx_q.delete();
    time_now = xs();
    wait_cyc(12);
    arst_n = 1'b1;
    want(MSG_LOST, 3'h0, 8'h00);
    wait_cyc(SET);
    i_term.link_up = 1'b1;
    drain();
    check(link_lost & printer_en, "lost at power-up");
    wrap_up();
  end
endmodule // slps_supervisor_tb_top
